//--- core/pod_defs.svh
// Offsets, field positions, reset values and timing counts of the positioning option block
`ifndef POD_DEFS_SVH
`define POD_DEFS_SVH

// ----------------------------------------------------------------
// Object indices
// ----------------------------------------------------------------
`define POD_IDX_OPTION 16'h60F2
`define POD_IDX_FOLLOW 16'h60F4
`define POD_IDX_DIN 16'h60FD

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define POD_OPTION_RST 16'h0001
`define POD_FOLLOW_RST 32'h0000_0000
`define POD_DIN_RST 32'h0000_0000

// ----------------------------------------------------------------
// Option word fields
// ----------------------------------------------------------------
`define POD_REL_LSB 0
`define POD_REL_MSB 1
`define POD_SREL_LSB 4
`define POD_SREL_MSB 5
`define POD_ROT_LSB 6
`define POD_ROT_MSB 7

// ----------------------------------------------------------------
// Input word fields
// ----------------------------------------------------------------
`define POD_DIN_NEG_LIMIT 0
`define POD_DIN_POS_LIMIT 1
`define POD_DIN_HOME 2
`define POD_DIN_GP_LSB 16
`define POD_DIN_GP_COUNT 8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define POD_SYNC_STAGES 2

`endif

//--- core/pod_pkg.sv
// Types shared by the positioning option block
package pod_pkg;

  typedef enum logic [1:0] {
    POD_REL_PREV_TARGET = 2'h0,
    POD_REL_RAMP = 2'h1,
    POD_REL_ACTUAL = 2'h2,
    POD_REL_RSVD = 2'h3
  } pod_rel_t;

  typedef enum logic [1:0] {
    POD_SREL_HANDSHAKE = 2'h0,
    POD_SREL_ON_REACHED = 2'h1,
    POD_SREL_ASAP = 2'h2,
    POD_SREL_RSVD = 2'h3
  } pod_srel_t;

  typedef enum logic [1:0] {
    POD_ROT_LINEAR = 2'h0,
    POD_ROT_NEG_ONLY = 2'h1,
    POD_ROT_POS_ONLY = 2'h2,
    POD_ROT_SHORTEST = 2'h3
  } pod_rot_t;

  typedef enum logic [3:0] {
    POD_ST_IDLE = 4'h1,
    POD_ST_HOLD = 4'h2,
    POD_ST_RELEASE = 4'h4,
    POD_ST_ACK_CLR = 4'h8
  } pod_state_t;

  typedef struct packed {
    pod_state_t st;
    logic [15:0] opt;
    logic new_q;
    logic have_tgt;
    logic [31:0] abs_tgt;
    logic dir_pos;
    logic wrap;
    logic start;
    logic sp_clr;
    logic ack_clr;
    logic [31:0] follow;
    logic [31:0] din;
    logic [31:0] rdata;
    logic ack;
    logic err;
  } pod_regs_t;

endpackage : pod_pkg

//--- core/pod_sync.sv
// Two-stage synchroniser for a group of pin inputs
module pod_sync import pod_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : pod_sync

//--- core/pod_rotary.sv
// Rotary direction policy and range wrap for a new absolute target
module pod_rotary import pod_pkg::*; (
  // Policy
  input wire pod_rot_t mode,
  // Positions
  input wire logic signed [31:0] target,
  input wire logic signed [31:0] actual,
  input wire logic signed [31:0] range_min,
  input wire logic signed [31:0] range_max,
  // Result
  output logic signed [31:0] target_out,
  output logic dir_pos,
  output logic wrap
);

  logic signed [32:0] span;
  logic signed [32:0] diff;
  logic signed [32:0] dmod;

  always_comb begin
    span = 33'(range_max) - 33'(range_min);
    diff = 33'(target) - 33'(actual);
    dmod = (diff < 0) ? diff + span : diff;
    target_out = target;
    dir_pos = (diff >= 0);
    wrap = 1'b0;
    case (mode)
      POD_ROT_LINEAR: begin
        // Reaching range_max or going below range_min moves the setpoint by one span toward the other end
        if (span > 0 && target >= range_max) begin
          target_out = 32'(33'(target) - span);
          wrap = 1'b1;
        end else if (span > 0 && target < range_min) begin
          target_out = 32'(33'(target) + span);
          wrap = 1'b1;
        end
      end
      POD_ROT_NEG_ONLY: begin
        dir_pos = 1'b0;
        wrap = (target > actual);
      end
      POD_ROT_POS_ONLY: begin
        dir_pos = 1'b1;
        wrap = (target < actual);
      end
      default: begin
        // Half a turn is span/2; below it the positive way is shorter
        dir_pos = (dmod < (span >>> 1));
        wrap = (dir_pos != (diff >= 0));
      end
    endcase
  end

endmodule : pod_rotary

//--- core/pod_top.sv
// Positioning option decode with following error and input word objects
// Summary of operation
// - Option word 16-bit RW, presets 0001h
// - Relative option used only when bit6 set
// - Code 00: base is previous target, else zero
// - Code 01: base is ramp generator output
// - Code 10: base is actual position
// - Auto release clears setpoint, then acknowledge
// - Code 00: no automatic setpoint release
// - Code 01: release when target reached
// - Code 10: release as soon as possible
// - Linear axis wraps at range limits
// - Code 01: negative direction only
// - Code 10: positive direction only
// - Code 11: shortest path direction
// - Signed following error, read only, zero preset
// - Limit and home switches in bits 0-2
// - General inputs 1-8 on bits 16-23
`include "pod_defs.svh"

module pod_top import pod_pkg::*; #(
  parameter int GP_INPUTS_USED = 8
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Object access
  input wire logic [15:0] OD_INDEX,
  input wire logic OD_WR,
  input wire logic OD_RD,
  input wire logic [31:0] OD_WDATA,
  output logic [31:0] OD_RDATA,
  output logic OD_ACK,
  output logic OD_ERR,
  // Controlword and statusword interface
  input wire logic CW_NEW_SETPOINT,
  input wire logic CW_RELATIVE,
  input wire logic TARGET_REACHED,
  output logic CW_SETPOINT_CLR,
  output logic SW_ACK_CLR,
  // Positions from ramp, encoder and limit objects
  input wire logic [31:0] TARGET_POS,
  input wire logic [31:0] RAMP_POS,
  input wire logic [31:0] ACTUAL_POS,
  input wire logic [31:0] RANGE_MIN,
  input wire logic [31:0] RANGE_MAX,
  // Move command to ramp generator
  output logic [31:0] ABS_TARGET,
  output logic MOVE_DIR_POS,
  output logic MOVE_WRAP,
  output logic MOVE_START,
  // Switch and input pins
  input wire logic NEGATIVE_LIMIT_SWITCH,
  input wire logic POSITIVE_LIMIT_SWITCH,
  input wire logic HOME_SWITCH,
  input wire logic [7:0] GP_IN
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [10:0] pins_raw;
  logic [10:0] pins_s;

  assign pins_raw = {GP_IN, HOME_SWITCH, POSITIVE_LIMIT_SWITCH, NEGATIVE_LIMIT_SWITCH};

  pod_sync #(.W(11)) u_sync (
    .clk(MCLK),
    .rst(RST),
    .d(pins_raw),
    .q(pins_s)
  );

  // Named views of the synchronised pins; nothing reads the raw pins
  logic neg_lim_s;
  logic pos_lim_s;
  logic home_s;
  logic [7:0] gp_s;
  logic [31:0] din_word;

  assign neg_lim_s = pins_s[0];
  assign pos_lim_s = pins_s[1];
  assign home_s = pins_s[2];
  assign gp_s = pins_s[10:3];

  // ----------------------------------------------------------------
  // Decoded option fields
  // ----------------------------------------------------------------
  pod_regs_t r;
  pod_regs_t n;
  pod_rel_t rel_sel;
  pod_srel_t srel_sel;
  pod_rot_t rot_sel;
  logic [7:0] gp_mask;
  logic signed [31:0] base;
  logic signed [31:0] new_tgt;
  logic signed [31:0] rot_tgt;
  logic rot_dir;
  logic rot_wrap;
  logic new_rise;

  always_comb begin
    // Reserved encodings fall back to the default behaviour
    rel_sel = pod_rel_t'(r.opt[`POD_REL_MSB:`POD_REL_LSB]);
    if (rel_sel == POD_REL_RSVD) begin
      rel_sel = POD_REL_PREV_TARGET;
    end
    srel_sel = pod_srel_t'(r.opt[`POD_SREL_MSB:`POD_SREL_LSB]);
    if (srel_sel == POD_SREL_RSVD) begin
      srel_sel = POD_SREL_HANDSHAKE;
    end
    rot_sel = pod_rot_t'(r.opt[`POD_ROT_MSB:`POD_ROT_LSB]);
  end

  // ----------------------------------------------------------------
  // Relative base and new target
  // ----------------------------------------------------------------
  always_comb begin
    // Previous target is the wrapped one, so chained relative moves stay in range under linear code 00 only
    case (rel_sel)
      POD_REL_RAMP: base = RAMP_POS;
      POD_REL_ACTUAL: base = ACTUAL_POS;
      default: base = r.have_tgt ? r.abs_tgt : 32'h0000_0000;
    endcase
    // Absolute moves ignore the relative base entirely
    new_tgt = CW_RELATIVE ? 32'(base + TARGET_POS) : TARGET_POS;
  end

  pod_rotary u_rotary (
    .mode(rot_sel),
    .target(new_tgt),
    .actual(ACTUAL_POS),
    .range_min(RANGE_MIN),
    .range_max(RANGE_MAX),
    .target_out(rot_tgt),
    .dir_pos(rot_dir),
    .wrap(rot_wrap)
  );

  // ----------------------------------------------------------------
  // Input word mask
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `POD_DIN_GP_COUNT; i++) begin
      gp_mask[i] = (i < GP_INPUTS_USED);
    end
  end

  // Bits outside the three switches and the used inputs read as zero
  always_comb begin
    din_word = `POD_DIN_RST;
    din_word[`POD_DIN_NEG_LIMIT] = neg_lim_s;
    din_word[`POD_DIN_POS_LIMIT] = pos_lim_s;
    din_word[`POD_DIN_HOME] = home_s;
    din_word[`POD_DIN_GP_LSB +: `POD_DIN_GP_COUNT] = gp_s & gp_mask;
  end

  // ----------------------------------------------------------------
  // Object index decode
  // ----------------------------------------------------------------
  logic hit_opt;
  logic hit_follow;
  logic hit_din;
  logic hit_ro;

  always_comb begin
    hit_opt = 1'b0;
    hit_follow = 1'b0;
    hit_din = 1'b0;
    if (OD_INDEX == `POD_IDX_OPTION) begin
      hit_opt = 1'b1;
    end else if (OD_INDEX == `POD_IDX_FOLLOW) begin
      hit_follow = 1'b1;
    end else if (OD_INDEX == `POD_IDX_DIN) begin
      hit_din = 1'b1;
    end
  end

  // Writes to these are refused without touching the object
  assign hit_ro = hit_follow || hit_din;

  assign new_rise = CW_NEW_SETPOINT && !r.new_q;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.new_q = CW_NEW_SETPOINT;
    n.start = 1'b0;
    n.sp_clr = 1'b0;
    n.ack_clr = 1'b0;
    n.ack = 1'b0;
    n.err = 1'b0;

    // Demand minus actual, wraps like the 32-bit signed object
    n.follow = 32'(RAMP_POS - ACTUAL_POS);

    n.din = din_word;

    // Setpoint sequencing
    // A rise outside idle is dropped, not queued: the controller must lower
    // the request before asking again
    case (r.st)
      POD_ST_IDLE: begin
        if (new_rise) begin
          n.abs_tgt = rot_tgt;
          n.have_tgt = 1'b1;
          n.dir_pos = rot_dir;
          n.wrap = rot_wrap;
          n.start = 1'b1;
          if (srel_sel == POD_SREL_ASAP) begin
            n.st = POD_ST_RELEASE;
          end else if (srel_sel == POD_SREL_ON_REACHED) begin
            n.st = POD_ST_HOLD;
          end else begin
            n.st = POD_ST_IDLE;
          end
        end
      end
      POD_ST_HOLD: begin
        // Reached flag may still show the previous move on the start cycle
        if (TARGET_REACHED && !r.start) begin
          n.st = POD_ST_RELEASE;
        end
      end
      POD_ST_RELEASE: begin
        n.sp_clr = 1'b1;
        n.st = POD_ST_ACK_CLR;
      end
      POD_ST_ACK_CLR: begin
        // Acknowledge drops only after the request has been released
        n.ack_clr = 1'b1;
        n.st = POD_ST_IDLE;
      end
      default: begin
        n.st = POD_ST_IDLE;
      end
    endcase

    // Object access
    if (OD_WR) begin
      n.ack = 1'b1;
      if (hit_opt) begin
        n.opt = OD_WDATA[15:0];
      end else if (hit_ro) begin
        // Read-only objects keep their value; the write is only refused
        n.err = 1'b1;
      end else begin
        n.err = 1'b1;
      end
    end else if (OD_RD) begin
      n.ack = 1'b1;
      if (hit_opt) begin
        n.rdata = {16'h0000, r.opt};
      end else if (hit_follow) begin
        n.rdata = r.follow;
      end else if (hit_din) begin
        n.rdata = r.din;
      end else begin
        n.rdata = 32'h0000_0000;
        n.err = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      r.st <= POD_ST_IDLE;
      r.opt <= `POD_OPTION_RST;
      r.new_q <= 1'b0;
      r.have_tgt <= 1'b0;
      r.abs_tgt <= 32'h0000_0000;
      r.dir_pos <= 1'b0;
      r.wrap <= 1'b0;
      r.start <= 1'b0;
      r.sp_clr <= 1'b0;
      r.ack_clr <= 1'b0;
      r.follow <= `POD_FOLLOW_RST;
      r.din <= `POD_DIN_RST;
      r.rdata <= 32'h0000_0000;
      r.ack <= 1'b0;
      r.err <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the state register
  assign OD_RDATA = r.rdata;
  assign OD_ACK = r.ack;
  assign OD_ERR = r.err;
  assign CW_SETPOINT_CLR = r.sp_clr;
  assign SW_ACK_CLR = r.ack_clr;
  assign ABS_TARGET = r.abs_tgt;
  assign MOVE_DIR_POS = r.dir_pos;
  assign MOVE_WRAP = r.wrap;
  assign MOVE_START = r.start;

endmodule : pod_top

//--- verification/pod_top_assertions.sv
// Port checker for object access and setpoint release timing
module pod_chk import pod_pkg::*; (
  // Clock, reset and object bus
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [15:0] OD_INDEX,
  input wire logic OD_WR,
  input wire logic OD_RD,
  input wire logic [31:0] OD_WDATA,
  input wire logic [31:0] OD_RDATA,
  input wire logic OD_ACK,
  input wire logic OD_ERR,
  // Setpoint and move
  input wire logic CW_NEW_SETPOINT,
  input wire logic TARGET_REACHED,
  input wire logic CW_SETPOINT_CLR,
  input wire logic SW_ACK_CLR,
  input wire logic [31:0] ACTUAL_POS,
  input wire logic [31:0] ABS_TARGET,
  input wire logic MOVE_DIR_POS,
  input wire logic MOVE_WRAP,
  input wire logic MOVE_START
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Shadow of the option word
  // ----------------------------------------------------------------
  logic [15:0] opt_r;
  logic [15:0] opt_nxt;
  always_comb begin
    opt_nxt = opt_r;
    if (OD_WR && OD_INDEX == 16'h60F2) begin
      opt_nxt = OD_WDATA[15:0];
    end
  end
  always_ff @(posedge MCLK) begin
    opt_r <= RST ? 16'h0001 : opt_nxt;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_take;
    CW_NEW_SETPOINT ##1 MOVE_START;
  endsequence
  sequence s_release;
    CW_SETPOINT_CLR ##1 SW_ACK_CLR;
  endsequence
  a_bus_ack: assert property ((OD_WR || OD_RD) |=> OD_ACK)
    else $error("request without ack");
  a_ro_refused: assert property (OD_WR &&
    (OD_INDEX == 16'h60F4 || OD_INDEX == 16'h60FD) |=> OD_ERR)
    else $error("write to read-only object accepted");
  a_opt_read: assert property (OD_RD && !OD_WR && OD_INDEX == 16'h60F2 |=>
    OD_RDATA == {16'h0000, opt_r} && !OD_ERR)
    else $error("option word read wrong");
  a_release_pair: assert property (CW_SETPOINT_CLR |=> SW_ACK_CLR)
    else $error("ack clear missing");
  a_ack_clr_cause: assert property (SW_ACK_CLR |-> $past(CW_SETPOINT_CLR))
    else $error("ack clear without setpoint clear");
  a_asap_release: assert property (s_take ##0 opt_r[5:4] == 2'h2 |=> s_release)
    else $error("early release missing");
  a_no_release: assert property (s_take ##0 opt_r[5] == opt_r[4]
    |=> !CW_SETPOINT_CLR [*8])
    else $error("release under handshake code");
  a_reached_release: assert property (CW_SETPOINT_CLR && opt_r[5:4] == 2'h1
    |-> $past(TARGET_REACHED, 2))
    else $error("release before target reached");
  a_neg_only: assert property (MOVE_START && opt_r[7:6] == 2'h1 |-> !MOVE_DIR_POS &&
    MOVE_WRAP == ($signed(ABS_TARGET) > $signed($past(ACTUAL_POS))))
    else $error("negative-only move wrong");
  a_pos_only: assert property (MOVE_START && opt_r[7:6] == 2'h2 |-> MOVE_DIR_POS &&
    MOVE_WRAP == ($signed(ABS_TARGET) < $signed($past(ACTUAL_POS))))
    else $error("positive-only move wrong");
  a_start_cause: assert property (MOVE_START |->
    $past(CW_NEW_SETPOINT) && !$past(CW_NEW_SETPOINT, 2))
    else $error("move start without setpoint rise");
endmodule : pod_chk

bind pod_top pod_chk chk_u (.MCLK, .RST, .OD_INDEX, .OD_WR, .OD_RD, .OD_WDATA, .OD_RDATA,
  .OD_ACK, .OD_ERR, .CW_NEW_SETPOINT, .TARGET_REACHED, .CW_SETPOINT_CLR, .SW_ACK_CLR,
  .ACTUAL_POS, .ABS_TARGET, .MOVE_DIR_POS, .MOVE_WRAP, .MOVE_START);

//--- verification/pod_axis.sv
// Axis model: settles on each target after a chosen delay, drives limit switches
module pod_axis (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Move command
  input wire logic start,
  input wire logic [31:0] target,
  input wire logic [3:0] lat,
  input wire logic [31:0] rmin,
  input wire logic [31:0] rmax,
  // Axis state
  output logic reached,
  output logic [31:0] pos,
  output logic neg_lim,
  output logic pos_lim
);
  timeunit 1ns;
  timeprecision 1ns;
  logic done_r;
  logic [3:0] cnt_r;
  // Drops at once on a new move, so a stale reached never releases it
  assign reached = done_r && !start;
  assign neg_lim = $signed(pos) <= $signed(rmin);
  assign pos_lim = $signed(pos) >= $signed(rmax);
  always @(posedge clk) begin
    if (rst) begin
      done_r <= 1'b1;
      pos <= 32'h0;
    end else if (start) begin
      done_r <= 1'b0;
      cnt_r <= lat;
    end else if (!done_r && cnt_r == 4'h0) begin
      done_r <= 1'b1;
      pos <= target;
    end else if (!done_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : pod_axis

//--- verification/tb_top.sv
// Bench: object access, input word and moves under every option code
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic MCLK = 0, RST = 1, OD_WR = 0, OD_RD = 0, CW_NEW_SETPOINT = 0, CW_RELATIVE = 0;
  logic HOME_SWITCH = 0;
  logic [15:0] OD_INDEX = 16'h0;
  logic [31:0] OD_WDATA = 0, TARGET_POS = 0, RAMP_POS = 0, RANGE_MIN = -1000, RANGE_MAX = 1000;
  logic [7:0] GP_IN = 8'h0;
  logic [3:0] lat = 4'h2;
  logic [31:0] OD_RDATA, ACTUAL_POS, ABS_TARGET, prev;
  logic OD_ACK, OD_ERR, TARGET_REACHED, CW_SETPOINT_CLR, SW_ACK_CLR, MOVE_DIR_POS, MOVE_WRAP;
  logic MOVE_START, NEGATIVE_LIMIT_SWITCH, POSITIVE_LIMIT_SWITCH;
  logic [31:0] q;
  logic e;
  int num_errors = 0, compares = 0, seed = 32'hda9aa45f;
  logic [15:0] idx[4] = '{16'h60F2, 16'h60F4, 16'h60FD, 16'h6000};
  always #4 MCLK = ~MCLK;
  pod_top #(.GP_INPUTS_USED(6)) dut_u (.MCLK, .RST, .OD_INDEX, .OD_WR, .OD_RD, .OD_WDATA,
    .OD_RDATA, .OD_ACK, .OD_ERR, .CW_NEW_SETPOINT, .CW_RELATIVE, .TARGET_REACHED,
    .CW_SETPOINT_CLR, .SW_ACK_CLR, .TARGET_POS, .RAMP_POS, .ACTUAL_POS, .RANGE_MIN,
    .RANGE_MAX, .ABS_TARGET, .MOVE_DIR_POS, .MOVE_WRAP, .MOVE_START, .NEGATIVE_LIMIT_SWITCH,
    .POSITIVE_LIMIT_SWITCH, .HOME_SWITCH, .GP_IN);
  pod_axis axis_u (.clk(MCLK), .rst(RST), .start(MOVE_START), .target(ABS_TARGET), .lat(lat),
    .rmin(RANGE_MIN), .rmax(RANGE_MAX), .reached(TARGET_REACHED), .pos(ACTUAL_POS),
    .neg_lim(NEGATIVE_LIMIT_SWITCH), .pos_lim(POSITIVE_LIMIT_SWITCH));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Entered right after a rising edge; leaves on one
  task od(input logic w, input logic [15:0] i, input logic [31:0] d);
    OD_WR <= w;
    OD_RD <= !w;
    OD_INDEX <= i;
    OD_WDATA <= d;
    @(posedge MCLK);
    OD_WR <= 1'b0;
    OD_RD <= 1'b0;
    #1;
    chk("ack", 32'h1, 32'(OD_ACK));
    q = OD_RDATA;
    e = OD_ERR;
    @(posedge MCLK);
  endtask : od
  function automatic logic sig(input int k);
    return k == 0 ? MOVE_START : (k == 1 ? CW_SETPOINT_CLR : TARGET_REACHED);
  endfunction : sig
  task wait_on(input int k);
    int n;
    n = 0;
    do begin
      @(posedge MCLK);
      #1;
      n++;
    end while (sig(k) !== 1'b1 && n < 40);
    chk("handshake", 32'h1, 32'(sig(k)));
  endtask : wait_on
  // Returns {wrap, dir, target}
  function automatic logic [33:0] exp_move(input logic [1:0] rot, input logic [31:0] t,
    input logic [31:0] a);
    logic signed [31:0] span, d;
    span = RANGE_MAX - RANGE_MIN;
    d = t - a;
    exp_move = {1'b0, !d[31], t};
    if (rot == 2'h0 && span > 0 && ($signed(t) >= $signed(RANGE_MAX))) begin
      exp_move = {2'b11 & {1'b1, !d[31]}, t - span};
    end else if (rot == 2'h0 && span > 0 && ($signed(t) < $signed(RANGE_MIN))) begin
      exp_move = {1'b1, !d[31], t + span};
    end
    if (rot == 2'h1) exp_move[33:32] = {$signed(t) > $signed(a), 1'b0};
    if (rot == 2'h2) exp_move[33:32] = {$signed(t) < $signed(a), 1'b1};
    if (rot == 2'h3) begin
      if (d < 0) d = d + span;
      exp_move[32] = d < (span >>> 1);
      exp_move[33] = exp_move[32] != ($signed(t) >= $signed(a));
    end
  endfunction : exp_move
  task move(input int i);
    logic [15:0] opt;
    logic [31:0] t;
    logic [33:0] x;
    opt = {8'($random(seed)), 2'(i + i / 4), 2'(i / 4), 2'h0, 2'(i)};
    od(1'b1, 16'h60F2, {16'hA5A5, opt});
    od(1'b0, 16'h60F2, 32'h0);
    chk("option", {16'h0, opt}, q);
    t = $random(seed) % 1500;
    RAMP_POS <= $random(seed) % 500;
    lat <= 4'(2 + ($random(seed) & 7));
    // Calls past the loop force a relative move to probe the zero base
    CW_RELATIVE <= 1'($random(seed)) | (i > 31);
    TARGET_POS <= t;
    CW_NEW_SETPOINT <= 1'b1;
    wait_on(0);
    if (CW_RELATIVE) begin
      t = t + (opt[1:0] == 2'h1 ? RAMP_POS : (opt[1:0] == 2'h2 ? ACTUAL_POS : prev));
    end
    x = exp_move(opt[7:6], t, ACTUAL_POS);
    prev = x[31:0];
    chk("target", x[31:0], ABS_TARGET);
    chk("direction", 32'(x[32]), 32'(MOVE_DIR_POS));
    chk("wrap", 32'(x[33]), 32'(MOVE_WRAP));
    if (opt[5] != opt[4]) wait_on(1);
    wait_on(2);
    @(posedge MCLK);
    CW_NEW_SETPOINT <= 1'b0;
    HOME_SWITCH <= 1'($random(seed));
    GP_IN <= 8'($random(seed));
    repeat (4) @(posedge MCLK);
    od(1'b0, 16'h60FD, 32'h0);
    chk("inputs", {8'h0, GP_IN & 8'h3F, 13'h0, HOME_SWITCH, POSITIVE_LIMIT_SWITCH,
      NEGATIVE_LIMIT_SWITCH}, q);
    od(1'b0, 16'h60F4, 32'h0);
    chk("follow", RAMP_POS - ACTUAL_POS, q);
    $display("test %0d done", i);
  endtask : move
  task end_of_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge MCLK);
    num_errors++;
    end_of_test();
  end
  initial begin
    prev = 32'h0;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      od(1'b0, idx[k], 32'h0);
      chk("reset value", k == 0 ? 32'h1 : 32'h0, q);
      chk("read refusal", 32'(k == 3), 32'(e));
      if (k > 0) od(1'b1, idx[k], 32'hFFFF_FFFF);
      if (k > 0) chk("write refusal", 32'h1, 32'(e));
    end
    $display("test reset done");
    for (int i = 0; i < 32; i++) move(i);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    prev = 32'h0;
    od(1'b0, 16'h60F2, 32'h0);
    chk("option after reset", 32'h1, q);
    move(48);
    end_of_test();
  end
endmodule : tb_top
